// file: hw/lane_array_host_command_unit.sv
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - 64 lanes share local memory; each lane has 16 data registers.
// - a shared 64 x 2048-bit vector file feeds the lanes.
// - each lane adds its base register to local-memory addresses.
// - conflicting local-memory accesses stall; all complete via simple arbitration.
// - register write stores third operand into lane/register chosen by others.
// - register read returns the selected lane register as third operand.
// - pack puts each lane's register into a vector, lane 0 lowest.
// - unpack loads each lane's register from its 32-bit vector slice.
// - traverse scans start to start plus length, returns packed lane value.
// - traverse reads the vector mapped to each lane by configuration.
// - launch starts each active lane at its pointer, input chosen by mode.
// - launch reports execution status at the operand memory address.
// - control write loads a lane's control fields from memory.
// - control read stores a lane's control fields to memory.
// - queue write fetches entry from memory into lane queue position.
// - queue read copies lane queue entry to memory.
// - configuration write loads configuration from memory.
// - configuration read stores configuration to memory.
// - mode bit clear selects vector input, set selects local memory.
// - a lane is done once its pointer reaches its limit.
// - after launch each active lane runs independently until done.
module lane_array_host_command_unit import lane_cmd_pkg::*; #(
  parameter int LANES = NUM_LANES,
  parameter int NREGS = NUM_DATA_REGS,
  parameter int VECS = NUM_VECS,
  parameter int QDEPTH = QUEUE_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic [31:0] mem_rdata_i,
  input wire logic mem_ack_i,
  output logic lm_req_o,
  output logic [31:0] lm_addr_o,
  input wire logic [31:0] lm_rdata_i,
  input wire logic lm_ack_i
);
  localparam int LW = $clog2(LANES);
  localparam int RW = $clog2(NREGS);
  localparam int VW = $clog2(VECS);
  localparam int QW = $clog2(QDEPTH);
  localparam int VEC_W = LANES * WORD_W;
  localparam int BW = $clog2(VEC_W / 8);
  localparam int CW = $clog2(LANES + 1);

  typedef enum logic [1:0] {S_IDLE, S_RUN, S_MEMRD, S_MEMWR} state_t;

  // ==================== storage ====================
  logic [31:0] data_reg [LANES][NREGS];
  logic [VEC_W-1:0] vrf_reg [VECS];
  logic [31:0] queue_reg [LANES][QDEPTH];
  logic [31:0] ptr_reg [LANES];
  logic [31:0] limit_reg [LANES];
  logic [31:0] misc_reg [LANES];
  logic [31:0] base_reg [LANES];
  logic [VW-1:0] map_reg [LANES];
  logic [LANES-1:0] act_reg;
  logic [LANES-1:0] result_reg;
  logic [31:0] op1_reg, op2_reg, op3_reg;
  logic [3:0] kind_reg;
  logic [31:0] addr_reg;
  logic [CW-1:0] cnt_reg;
  logic trav_reg;
  logic ack_reg;
  logic [LW-1:0] rr_reg;
  state_t state_reg;

  // ==================== helpers ====================
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      if (be[b]) old[b*8 +: 8] = d[b*8 +: 8];
    end
    return old;
  endfunction : be_merge

  function automatic logic [LW-1:0] pick(input logic [LANES-1:0] req, input logic [LW-1:0] start);
    logic [LW-1:0] sel;
    sel = start;
    for (int k = LANES - 1; k >= 0; k--) begin
      if (req[LW'((32'(start) + k) % LANES)]) sel = LW'((32'(start) + k) % LANES);
    end
    return sel;
  endfunction : pick

  // ==================== decode ====================
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire bus_wr = bus_req & wb_we_i;
  wire idle = (state_reg == S_IDLE);
  wire cmd_go = bus_wr & (wb_adr_i == OFF_CMD) & wb_sel_i[0] & idle;
  wire [3:0] opc = wb_dat_i[3:0];
  wire [LW-1:0] ln = op1_reg[LW-1:0];
  wire [RW-1:0] rg = op2_reg[RW-1:0];
  wire [RW-1:0] prg = op1_reg[RW-1:0];
  wire [VW-1:0] pvec = op2_reg[VW-1:0];
  wire [QW-1:0] qpos = op2_reg[QW-1:0];
  wire [LW-1:0] cln = op2_reg[LW-1:0];
  wire [LW-1:0] wl = cnt_reg[LW-1:0];
  wire mem_last = (kind_reg == CMD_CFG_WR || kind_reg == CMD_CFG_RD) ?
                  (cnt_reg == CW'(LANES - 1)) :
                  (kind_reg == CMD_CTRL_WR || kind_reg == CMD_CTRL_RD) ?
                  (cnt_reg == CW'(CTRL_WORDS - 1)) : 1'b1;

  logic [LANES-1:0] done_w, busy_w, want_w;
  logic [31:0] adv_w [LANES];
  logic [7:0] byte_w [LANES];
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign done_w[g] = ptr_reg[g] >= limit_reg[g];
    assign busy_w[g] = act_reg[g] & ~done_w[g];
    assign want_w[g] = (state_reg == S_RUN) & busy_w[g] & ~trav_reg & misc_reg[g][MODE_BIT];
    assign adv_w[g] = trav_reg ? 32'(TRAV_STEP) :
                      (misc_reg[g][ADV_MSB:ADV_LSB] == 3'h0) ? 32'h1 :
                      32'(misc_reg[g][ADV_MSB:ADV_LSB]);
    assign byte_w[g] = vrf_reg[map_reg[g]][{ptr_reg[g][BW+2:3], 3'b000} +: 8];
  end

  wire all_done = ~|busy_w;
  wire [LW-1:0] gnt = pick(want_w, rr_reg);
  assign lm_req_o = |want_w;
  assign lm_addr_o = base_reg[gnt] + {3'b000, ptr_reg[gnt][31:3]};
  assign mem_req_o = (state_reg == S_MEMRD) | (state_reg == S_MEMWR);
  assign mem_we_o = (state_reg == S_MEMWR);
  assign mem_addr_o = addr_reg + 32'({cnt_reg, 2'b00});
  assign wb_ack_o = ack_reg;

  logic [31:0] ctrl_word;
  always_comb begin
    case (cnt_reg[1:0])
      2'd0: ctrl_word = ptr_reg[cln];
      2'd1: ctrl_word = limit_reg[cln];
      2'd2: ctrl_word = {misc_reg[cln][31:DONE_BIT+1], done_w[cln], misc_reg[cln][DONE_BIT-1:0]};
      default: ctrl_word = base_reg[cln];
    endcase
  end

  always_comb begin
    case (kind_reg)
      CMD_CTRL_RD: mem_wdata_o = ctrl_word;
      thread_queue_read_cmd: mem_wdata_o = queue_reg[ln][qpos];
      CMD_CFG_RD: mem_wdata_o = 32'({act_reg[wl], (CFG_ACT_BIT)'(map_reg[wl])});
      CMD_LAUNCH: mem_wdata_o = LAUNCH_DONE_WORD;
      default: mem_wdata_o = ZERO_WORD;
    endcase
  end

  always_comb begin
    case (wb_adr_i)
      OFF_OP1: wb_dat_o = op1_reg;
      OFF_OP2: wb_dat_o = op2_reg;
      OFF_OP3: wb_dat_o = op3_reg;
      OFF_STATUS: wb_dat_o = {31'h0, ~idle};
      OFF_RES_LO: wb_dat_o = result_reg[31:0];
      OFF_RES_HI: wb_dat_o = result_reg[LANES-1:32];
      default: wb_dat_o = ZERO_WORD;
    endcase
  end

  // ==================== sequencing ====================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      ack_reg <= 1'b0;
      op1_reg <= ZERO_WORD;
      op2_reg <= ZERO_WORD;
      op3_reg <= ZERO_WORD;
      kind_reg <= 4'h0;
      addr_reg <= ZERO_WORD;
      cnt_reg <= '0;
      trav_reg <= 1'b0;
      rr_reg <= '0;
      result_reg <= '0;
    end else begin
      ack_reg <= bus_req;
      if (bus_wr && wb_adr_i == OFF_OP1 && idle) op1_reg <= be_merge(op1_reg, wb_dat_i, wb_sel_i);
      if (bus_wr && wb_adr_i == OFF_OP2 && idle) op2_reg <= be_merge(op2_reg, wb_dat_i, wb_sel_i);
      if (bus_wr && wb_adr_i == OFF_OP3 && idle) op3_reg <= be_merge(op3_reg, wb_dat_i, wb_sel_i);
      if (lm_ack_i && lm_req_o) rr_reg <= LW'(32'(gnt) + 1);
      cnt_reg <= '0;
      case (state_reg)
        S_IDLE: if (cmd_go) begin
          kind_reg <= opc;
          case (opc)
            CMD_REG_RD: op3_reg <= data_reg[ln][rg];
            CMD_TRAVERSE: begin
              trav_reg <= 1'b1;
              state_reg <= S_RUN;
            end
            CMD_LAUNCH: begin
              trav_reg <= 1'b0;
              addr_reg <= op1_reg;
              state_reg <= S_RUN;
            end
            CMD_CTRL_WR, CMD_CFG_WR: begin
              addr_reg <= op1_reg;
              state_reg <= S_MEMRD;
            end
            CMD_CTRL_RD, CMD_CFG_RD: begin
              addr_reg <= op1_reg;
              state_reg <= S_MEMWR;
            end
            thread_queue_write_cmd: begin
              addr_reg <= op3_reg;
              state_reg <= S_MEMRD;
            end
            thread_queue_read_cmd: begin
              addr_reg <= op3_reg;
              state_reg <= S_MEMWR;
            end
            default: state_reg <= S_IDLE;
          endcase
        end
        S_RUN: if (all_done) begin
          state_reg <= trav_reg ? S_IDLE : S_MEMWR;
          for (int l = 0; l < LANES; l++) result_reg[l] <= data_reg[l][0][0];
        end
        default: begin
          cnt_reg <= cnt_reg;
          if (mem_ack_i) begin
            cnt_reg <= CW'(32'(cnt_reg) + 1);
            if (mem_last) state_reg <= S_IDLE;
          end
        end
      endcase
    end
  end

  // ==================== lane state ====================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int l = 0; l < LANES; l++) begin
        ptr_reg[l] <= ZERO_WORD;
        limit_reg[l] <= ZERO_WORD;
        misc_reg[l] <= ZERO_WORD;
        base_reg[l] <= ZERO_WORD;
        map_reg[l] <= VW'(l);
      end
      act_reg <= '0;
    end else begin
      if (cmd_go) begin
        case (opc)
          CMD_REG_WR: data_reg[ln][rg] <= op3_reg;
          CMD_PACK: for (int l = 0; l < LANES; l++) vrf_reg[pvec][l*WORD_W +: WORD_W] <= data_reg[l][prg];
          CMD_UNPACK: for (int l = 0; l < LANES; l++) data_reg[l][prg] <= vrf_reg[pvec][l*WORD_W +: WORD_W];
          CMD_TRAVERSE: for (int l = 0; l < LANES; l++) begin
            if (act_reg[l]) begin
              ptr_reg[l] <= op1_reg;
              limit_reg[l] <= op1_reg + op2_reg;
            end
          end
          default: ;
        endcase
      end
      if (state_reg == S_RUN) begin
        for (int l = 0; l < LANES; l++) begin
          if (busy_w[l] && (trav_reg || !misc_reg[l][MODE_BIT])) begin
            data_reg[l][0] <= {24'h0, byte_w[l]};
            ptr_reg[l] <= ptr_reg[l] + adv_w[l];
          end else if (busy_w[l] && lm_ack_i && gnt == LW'(l)) begin
            data_reg[l][0] <= lm_rdata_i;
            ptr_reg[l] <= ptr_reg[l] + adv_w[l];
          end
        end
      end
      if (state_reg == S_MEMRD && mem_ack_i) begin
        case (kind_reg)
          CMD_CTRL_WR: case (cnt_reg[1:0])
            2'd0: ptr_reg[cln] <= mem_rdata_i;
            2'd1: limit_reg[cln] <= mem_rdata_i;
            2'd2: misc_reg[cln] <= mem_rdata_i;
            default: base_reg[cln] <= mem_rdata_i;
          endcase
          thread_queue_write_cmd: queue_reg[ln][qpos] <= mem_rdata_i;
          CMD_CFG_WR: begin
            map_reg[wl] <= mem_rdata_i[VW-1:0];
            act_reg[wl] <= mem_rdata_i[CFG_ACT_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  // ==================== checks ====================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_reg_wr;
    cmd_go && opc == CMD_REG_WR |=> data_reg[$past(ln)][$past(rg)] == $past(op3_reg);
  endproperty
  a_reg_wr: assert property (p_reg_wr) else $error("register write lost");

  property p_reg_rd;
    cmd_go && opc == CMD_REG_RD |=> op3_reg == $past(data_reg[ln][rg]);
  endproperty
  a_reg_rd: assert property (p_reg_rd) else $error("register read wrong");

  property p_pack;
    cmd_go && opc == CMD_PACK |=> vrf_reg[$past(pvec)][31:0] == $past(data_reg[0][prg]);
  endproperty
  a_pack: assert property (p_pack) else $error("pack lane 0 slice wrong");

  property p_unpack;
    cmd_go && opc == CMD_UNPACK |=>
      data_reg[LANES-1][$past(prg)] == $past(vrf_reg[pvec][VEC_W-1 -: WORD_W]);
  endproperty
  a_unpack: assert property (p_unpack) else $error("unpack top slice wrong");

  property p_inactive;
    state_reg == S_RUN && !act_reg[1] |=> $stable(ptr_reg[1]);
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive lane moved");

  property p_stall;
    lm_req_o && !lm_ack_i |=> lm_req_o && $stable(lm_addr_o);
  endproperty
  a_stall: assert property (p_stall) else $error("stalled access dropped");

  property p_report;
    state_reg == S_RUN && all_done && !trav_reg |=>
      mem_req_o && mem_we_o && mem_addr_o == $past(addr_reg) && mem_wdata_o == LAUNCH_DONE_WORD;
  endproperty
  a_report: assert property (p_report) else $error("launch status not reported");

  property p_hold;
    !idle && !(state_reg == S_MEMRD && mem_ack_i) && bus_wr && wb_adr_i == OFF_CMD
      |=> kind_reg == $past(kind_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("command taken while busy");

  property p_ack;
    bus_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
endmodule : lane_array_host_command_unit
`default_nettype wire

// file: hw/lane_cmd_pkg.sv
package lane_cmd_pkg;
  // ==================== geometry ====================
  localparam int NUM_LANES = 64;
  localparam int NUM_DATA_REGS = 16;
  localparam int NUM_VECS = 64;
  localparam int WORD_W = 32;
  localparam int QUEUE_DEPTH = 8;
  localparam int CTRL_WORDS = 4;
  localparam int ADR_W = 8;
  // ==================== bus offsets ====================
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_OP1 = 8'h04;
  localparam logic [7:0] OFF_OP2 = 8'h08;
  localparam logic [7:0] OFF_OP3 = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_RES_LO = 8'h14;
  localparam logic [7:0] OFF_RES_HI = 8'h18;
  // ==================== command codes ====================
  localparam logic [3:0] CMD_REG_WR = 4'h1;
  localparam logic [3:0] CMD_REG_RD = 4'h2;
  localparam logic [3:0] CMD_PACK = 4'h3;
  localparam logic [3:0] CMD_UNPACK = 4'h4;
  localparam logic [3:0] CMD_TRAVERSE = 4'h5;
  localparam logic [3:0] CMD_LAUNCH = 4'h6;
  localparam logic [3:0] CMD_CTRL_WR = 4'h7;
  localparam logic [3:0] CMD_CTRL_RD = 4'h8;
  localparam logic [3:0] thread_queue_write_cmd = 4'h9;
  localparam logic [3:0] thread_queue_read_cmd = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam logic [3:0] CMD_CFG_RD = 4'hc;
  // ==================== control word 2 fields, config active bit, constants ====================
  localparam int ADV_LSB = 5;
  localparam int ADV_MSB = 7;
  localparam int DONE_BIT = 2;
  localparam int MODE_BIT = 1;
  localparam int CFG_ACT_BIT = 8;
  localparam int TRAV_STEP = 8;
  localparam logic [31:0] LAUNCH_DONE_WORD = 32'h0000_0001;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage : lane_cmd_pkg

// file: verification/lane_array_host_command_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lane_array_host_command_unit_bench import lane_cmd_pkg::*;;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow, lm_seen;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic [31:0] lm_addr_o, lm_rdata_i, first_lm, r;
  logic mem_req_o, mem_we_o, mem_ack_i, lm_req_o, lm_ack_i;
  int n_fail, checked, cycles;
  lane_array_host_command_unit dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .lm_req_o(lm_req_o),
    .lm_addr_o(lm_addr_o), .lm_rdata_i(lm_rdata_i), .lm_ack_i(lm_ack_i));
  lane_mem_model mem (.clk_i(clk_i), .slow_i(slow), .mem_req_i(mem_req_o),
    .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
    .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i), .lm_req_i(lm_req_o),
    .lm_addr_i(lm_addr_o), .lm_rdata_o(lm_rdata_i), .lm_ack_o(lm_ack_i));
  // ==========================================
  // clock, timeout, probes
  // ==========================================
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (lm_req_o && lm_ack_i && !lm_seen) begin
      first_lm <= lm_addr_o;
      lm_seen <= 1'b1;
    end
    if (cycles == 60000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // ==========================================
  // shared tasks
  // ==========================================
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : bus
  // operands first, command last, then poll until the unit is idle again
  task automatic cmd(input logic [3:0] code, input logic [31:0] a, b, c);
    logic [31:0] s;
    bus(1'b1, OFF_OP1, a, s);
    bus(1'b1, OFF_OP2, b, s);
    bus(1'b1, OFF_OP3, c, s);
    bus(1'b1, OFF_CMD, {28'h0, code}, s);
    s = 32'h1;
    while (s[0] !== 1'b0) bus(1'b0, OFF_STATUS, ZERO_WORD, s);
  endtask : cmd
  task automatic rd_reg(input int k, input int g, output logic [31:0] d);
    cmd(CMD_REG_RD, k, g, 0);
    bus(1'b0, OFF_OP3, ZERO_WORD, d);
  endtask : rd_reg
  // ==========================================
  // scenarios
  // ==========================================
  task automatic t_regs();
    int ln [3] = '{0, 63, 5};
    int rg [3] = '{0, 15, 7};
    for (int i = 0; i < 3; i++) cmd(CMD_REG_WR, ln[i], rg[i], 32'hcafe_0000 + i);
    for (int i = 0; i < 3; i++) begin
      rd_reg(ln[i], rg[i], r);
      chk("lane reg", r, 32'hcafe_0000 + i);
    end
  endtask : t_regs
  task automatic t_vector();
    for (int k = 0; k < 64; k++) begin
      cmd(CMD_REG_WR, k, 3, 32'h3c00_0000 + k);
      cmd(CMD_REG_WR, k, 0, 0);
      mem.words[64 + k] = {23'h0, k[0] == 1'b0, 2'h0, 6'd9};
    end
    cmd(CMD_PACK, 3, 9, 0);
    cmd(CMD_UNPACK, 4, 9, 0);
    rd_reg(0, 4, r);
    chk("unpack lane 0", r, 32'h3c00_0000);
    rd_reg(63, 4, r);
    chk("unpack lane 63", r, 32'h3c00_003f);
    slow <= 1'b1;
    cmd(CMD_CFG_WR, 32'h100, 0, 0);
    // a second command and an operand write while busy must both be ignored
    bus(1'b1, OFF_OP1, 32'h200, r);
    bus(1'b1, OFF_CMD, {28'h0, CMD_CFG_RD}, r);
    bus(1'b1, OFF_OP1, 32'h55, r);
    bus(1'b1, OFF_CMD, {28'h0, CMD_REG_WR}, r);
    r = 32'h1;
    while (r[0] !== 1'b0) bus(1'b0, OFF_STATUS, ZERO_WORD, r);
    bus(1'b0, OFF_OP1, ZERO_WORD, r);
    chk("busy refusal", r, 32'h200);
    slow <= 1'b0;
    for (int k = 0; k < 64; k++) chk("cfg", mem.words[128 + k] & 32'h13f, mem.words[64 + k]);
    // all lanes mapped to vector 9; only even lanes active, so odd result bits stay 0
    cmd(CMD_TRAVERSE, 2016, 8, 0);
    bus(1'b0, OFF_RES_LO, ZERO_WORD, r);
    chk("scan top lo", r, 32'h5555_5555);
    bus(1'b0, OFF_RES_HI, ZERO_WORD, r);
    chk("scan top hi", r, 32'h5555_5555);
    cmd(CMD_TRAVERSE, 0, 8, 0);
    bus(1'b0, OFF_RES_LO, ZERO_WORD, r);
    chk("scan bottom", r, ZERO_WORD);
  endtask : t_vector
  task automatic t_launch();
    for (int k = 0; k < 64; k++) mem.words[k] = {23'h0, k == 0 || k == 2, 2'h0, 6'd9};
    mem.words[192:199] = '{0, 24, 32'he0, 32'h40, 0, 24, 32'he2, 32'h80};
    mem.words[252] = ZERO_WORD;
    cmd(CMD_CFG_WR, 0, 0, 0);
    cmd(CMD_CTRL_WR, 32'h300, 0, 0);
    cmd(CMD_CTRL_WR, 32'h310, 2, 0);
    cmd(CMD_LAUNCH, 32'h3f0, 0, 0);
    chk("status word", mem.words[252], LAUNCH_DONE_WORD);
    chk("local fetch", {31'h0, lm_seen}, 32'h1);
    chk("first local addr", first_lm, 32'h80);
    cmd(CMD_CTRL_RD, 32'h340, 0, 0);
    cmd(CMD_CTRL_RD, 32'h350, 2, 0);
    for (int j = 0; j < 2; j++) begin
      chk("reached", {31'h0, mem.words[208 + 4 * j] >= 32'd24}, 32'h1);
      chk("limit", mem.words[209 + 4 * j], 32'd24);
      chk("done", {31'h0, mem.words[210 + 4 * j][2]}, 32'h1);
      chk("mode", {31'h0, mem.words[210 + 4 * j][1]}, j);
      chk("base", mem.words[211 + 4 * j], j ? 32'h80 : 32'h40);
    end
  endtask : t_launch
  task automatic t_queue();
    mem.words[248] = 32'hbeef_1234;
    mem.words[249] = ZERO_WORD;
    cmd(thread_queue_write_cmd, 63, 7, 32'h3e0);
    cmd(thread_queue_read_cmd, 63, 7, 32'h3e4);
    chk("queue entry", mem.words[249], 32'hbeef_1234);
  endtask : t_queue
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0000_0000;
    slow = 1'b0;
    lm_seen = 1'b0;
    first_lm = 32'h0000_0000;
    n_fail = 0;
    checked = 0;
    cycles = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_vector();
    t_launch();
    t_queue();
    bus(1'b0, 8'h40, ZERO_WORD, r);
    chk("unmapped", r, ZERO_WORD);
    report_and_stop();
  end
endmodule : lane_array_host_command_unit_bench
`default_nettype wire

// file: verification/lane_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host memory and lane local memory
// ==========================================
module lane_mem_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  output logic [31:0] mem_rdata_o,
  output logic mem_ack_o,
  input wire logic lm_req_i,
  input wire logic [31:0] lm_addr_i,
  output logic [31:0] lm_rdata_o,
  output logic lm_ack_o
);
  logic [31:0] words [0:255];
  logic [1:0] wait_reg;
  initial begin
    mem_ack_o = 1'b0;
    mem_rdata_o = 32'h0000_0000;
    lm_ack_o = 1'b0;
    lm_rdata_o = 32'h0000_0000;
    wait_reg = 2'h0;
  end
  // read data toggles outside ack so a stale word is never mistaken for an answer
  always @(posedge clk_i) begin
    if (mem_req_i && mem_ack_o && mem_we_i) begin
      words[mem_addr_i[9:2]] <= mem_wdata_i;
    end
    if (mem_ack_o || !mem_req_i) begin
      mem_ack_o <= 1'b0;
      wait_reg <= slow_i ? 2'h3 : 2'h0;
      mem_rdata_o <= ~mem_rdata_o;
    end else if (wait_reg != 2'h0) begin
      wait_reg <= wait_reg - 2'h1;
      mem_rdata_o <= ~mem_rdata_o;
    end else begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= words[mem_addr_i[9:2]];
    end
  end
  always @(posedge clk_i) begin
    if (lm_ack_o || !lm_req_i) begin
      lm_ack_o <= 1'b0;
      lm_rdata_o <= ~lm_rdata_o;
    end else begin
      lm_ack_o <= 1'b1;
      lm_rdata_o <= {lm_addr_i[15:0], 16'h5a5a};
    end
  end
endmodule : lane_mem_model
`default_nettype wire
